// File: trcc_pkg.sv
// trcc_pkg: register indices, field positions, reset values and timing counts
package trcc_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register indices (byte address on the bus is four times the index)
	localparam logic [7:0]  IDX_CAP_EN_FLAGS = 8'h92;
	localparam logic [7:0]  IDX_CAP_EDGE     = 8'h93;
	localparam logic [7:0]  IDX_CAP_FILT     = 8'h94;
	localparam logic [7:0]  IDX_IRQ_EN       = 8'hA8;
	localparam logic [7:0]  IDX_TMR_CTRL     = 8'hC8;
	localparam logic [7:0]  IDX_TMR_MODE     = 8'hC9;
	localparam logic [7:0]  IDX_RLD_LO       = 8'hCA;
	localparam logic [7:0]  IDX_RLD_HI       = 8'hCB;
	localparam logic [7:0]  IDX_CNT_LO       = 8'hCC;
	localparam logic [7:0]  IDX_CNT_HI       = 8'hCD;
	localparam logic [7:0]  IDX_CAP0_LO      = 8'hE4;
	localparam logic [7:0]  IDX_CAP0_HI      = 8'hE5;
	localparam logic [7:0]  IDX_CAP1_LO      = 8'hE6;
	localparam logic [7:0]  IDX_CAP1_HI      = 8'hE7;
	localparam logic [7:0]  IDX_CAP2_LO      = 8'hED;
	localparam logic [7:0]  IDX_CAP2_HI      = 8'hEE;

	////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int          CTRL_FLAG_BIT    = 7;
	localparam int          CTRL_RUN_BIT     = 2;
	localparam int          CTRL_MODE_BIT    = 0;
	localparam int          MODE_RLD_EN_BIT  = 7;
	localparam int          MODE_CAP_CLR_BIT = 3;
	localparam int          MODE_CMP_CLR_BIT = 2;
	localparam int          CAP_EN_LSB       = 4;
	localparam int          CAP_FLAG_LSB     = 0;
	localparam int          FILT_EN_LSB      = 4;
	localparam int          IRQ_CAP_EN_BIT   = 0;
	localparam int          IRQ_GLB_EN_BIT   = 1;

	////////////////////////////////////////////////////////////////////////////
	// writable-bit masks; other bits read as zero
	localparam logic [7:0]  CAP_EN_FLAGS_MASK = 8'h77;
	localparam logic [7:0]  CAP_EDGE_MASK     = 8'h3F;
	localparam logic [7:0]  CAP_FILT_MASK     = 8'h70;
	localparam logic [7:0]  TMR_CTRL_MASK     = 8'h85;
	localparam logic [7:0]  TMR_MODE_MASK     = 8'h8F;
	localparam logic [7:0]  IRQ_EN_MASK       = 8'h03;

	////////////////////////////////////////////////////////////////////////////
	// reset values and counter constants
	localparam logic [7:0]  REG_RST          = 8'h00;
	localparam logic [15:0] CNT_RST          = 16'h0000;
	localparam logic [15:0] CNT_CLEAR        = 16'h0000;
	localparam logic [15:0] CNT_MAX          = 16'hFFFF;

	////////////////////////////////////////////////////////////////////////////
	// encodings
	localparam logic [1:0]  EDGE_FALL        = 2'h0;
	localparam logic [1:0]  EDGE_RISE        = 2'h1;
	localparam logic [1:0]  EDGE_ANY         = 2'h2;
	localparam logic [1:0]  TRIG_OVF         = 2'h0;
	localparam logic [1:0]  TRIG_CAP0        = 2'h1;
	localparam logic [1:0]  TRIG_CAP1        = 2'h2;
	localparam logic [1:0]  TRIG_CAP2        = 2'h3;

	////////////////////////////////////////////////////////////////////////////
	// timing: shortest accepted pulse, as time and as clock cycles (rounded up)
	localparam int          CLK_PERIOD_NS    = 10;
	localparam int          FILT_MIN_NS      = 40;
	localparam int          FILT_CYCLES      = (FILT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0]  FILT_CNT_LAST    = 3'(FILT_CYCLES - 1);

	////////////////////////////////////////////////////////////////////////////
	// sizes
	localparam int          NUM_CH           = 3;
	localparam int          ADDR_W           = 10;

endpackage : trcc_pkg

// File: trcc_chan.sv
// trcc_chan: one capture input channel with glitch filter and edge detector
module trcc_chan (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rstn,
	// pin and channel controls
	input  wire logic       pin_in,
	input  wire logic       chan_en,
	input  wire logic       filt_en,
	input  wire logic [1:0] edge_sel,
	// one-cycle capture event
	output logic            cap_evt
);

	logic [2:0] run_q;
	logic       lvl_q;
	logic       prev_q;
	logic       rise;
	logic       fall;
	logic       hit;

	////////////////////////////////////////////////////////////////////////////
	// four-cycle glitch filter
	// the level moves only after the pin has differed for four samples in a row
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			lvl_q <= 1'b0;
			run_q <= 3'h0;
		end else if (!filt_en || pin_in == lvl_q) begin
			lvl_q <= pin_in;
			run_q <= 3'h0;
		end else if (run_q == trcc_pkg::FILT_CNT_LAST) begin
			lvl_q <= pin_in;
			run_q <= 3'h0;
		end else begin
			run_q <= run_q + 3'h1;
		end
	end

	// edge history on the filtered level
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= lvl_q;
		end
	end

	assign rise = lvl_q & ~prev_q;
	assign fall = ~lvl_q & prev_q;

	always_comb begin
		unique case (edge_sel)
			trcc_pkg::EDGE_FALL: hit = fall;
			trcc_pkg::EDGE_RISE: hit = rise;
			trcc_pkg::EDGE_ANY:  hit = rise | fall;
			default:             hit = 1'b0;
		endcase
	end

	assign cap_evt = chan_en & hit;

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);

	filt_reject_a: assert property ($changed(lvl_q) && $past(filt_en, 1) && $past(filt_en, 2)
		&& $past(filt_en, 3) && $past(filt_en, 4) |-> $past(pin_in, 1) == lvl_q
		&& $past(pin_in, 2) == lvl_q && $past(pin_in, 3) == lvl_q && $past(pin_in, 4) == lvl_q)
		else $error("filtered level moved on a pulse shorter than four cycles");
	edge_cause_a: assert property (cap_evt |-> lvl_q != prev_q && chan_en)
		else $error("capture event without an edge");
	rsvd_silent_a: assert property (edge_sel == 2'h3 |-> !cap_evt)
		else $error("reserved edge code produced an event");

endmodule : trcc_chan

// File: trcc_cap.sv
// trcc_cap: one 16-bit capture result register pair
module trcc_cap (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rstn,
	// capture load
	input  wire logic        load,
	input  wire logic [15:0] cnt_val,
	// software byte writes
	input  wire logic        wr_lo,
	input  wire logic        wr_hi,
	input  wire logic [7:0]  wdata,
	// stored result
	output logic      [15:0] cap_q
);

	// a capture beats a software write in the same cycle
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cap_q <= trcc_pkg::CNT_RST;
		end else if (load) begin
			cap_q <= cnt_val;
		end else if (wr_lo) begin
			cap_q <= {cap_q[15:8], wdata};
		end else if (wr_hi) begin
			cap_q <= {wdata, cap_q[7:0]};
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);

	cap_store_a: assert property (load |=> cap_q == $past(cnt_val))
		else $error("capture register did not take the counter value");

endmodule : trcc_cap

// File: trcc_top.sv
// trcc_top: 16-bit reload/compare timer with three-channel input capture
//
// Notes on behaviour
// - mode bit clear selects auto-reload; pair holds the reload value
// - with reload enable, selected event copies reload pair into counter
// - trigger select field at mode bits 1:0 picks overflow or capture channel
// - auto-reload with capture auto-clear: capture clears counter, no reload
// - mode bit set selects compare; pair holds the compare value
// - in compare mode counter equal to compare sets the overflow/match flag
// - compare auto-clear resets counter to zero after a match
// - three independent capture channels, each on its own pin, one counter
// - per-channel filter enable at bits 6:4 rejects pulses under four cycles
// - per-channel edge code: 00 falling, 01 rising, 10 either, 11 reserved
// - channel acts only while its enable bit (bits 6:4) is set
// - selected edge copies the counter into that channel's capture pair
// - selected edge sets channel flag at bit 0, 1 or 2
// - one capture interrupt when any flag set and both enables set
// - in auto-reload mode, capture auto-clear zeroes counter on the same clock edge that stores the value
// - capture control registers reset to zero
// - trigger 00 overflow; 01, 10, 11 capture channel 0, 1, 2
// - overflow/match flag cleared only by software
// - run bit low holds the counter except for writes, capture clear and capture reload; high resumes counting
//
// Register access over Avalon-MM was left to the implementer.
module trcc_top (
	// clock and reset
	input  wire logic                        core_clk,
	input  wire logic                        rstn,
	// register bus
	input  wire logic [trcc_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire logic [31:0]                 avs_writedata,
	input  wire logic [3:0]                  avs_byteenable,
	output logic      [31:0]                 avs_readdata,
	output logic                             avs_waitrequest,
	// capture pins
	input  wire logic                        capture_in_0,
	input  wire logic                        capture_in_1,
	input  wire logic                        capture_in_2,
	// interrupt request
	output logic                             capture_irq
);

	logic [7:0]  cap_ctl_q;
	logic [7:0]  edge_q;
	logic [7:0]  filt_q;
	logic [7:0]  ctrl_q;
	logic [7:0]  mode_q;
	logic [1:0]  irq_en_q;
	logic [15:0] rld_q;
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic        ack_q;
	logic        irq_q;
	logic [31:0] rdata_q;
	logic [7:0]  idx;
	logic [7:0]  wbyte;
	logic [7:0]  rd_byte;
	logic        req;
	logic        wr_acc;
	logic [2:0]  pins;
	logic [2:0]  cap_evt;
	logic [15:0] cap_val [trcc_pkg::NUM_CH];
	logic [2:0]  wr_cap_lo;
	logic [2:0]  wr_cap_hi;
	logic        wr_cnt_lo;
	logic        wr_cnt_hi;
	logic        wr_ctrl;
	logic        run;
	logic        cmp_mode;
	logic        ovf;
	logic        match;
	logic        reload_evt;
	logic        cap_clr;
	logic        reload;
	logic        cmp_clr;
	logic        any_cap;

	////////////////////////////////////////////////////////////////////////////
	// bus slave: one wait cycle, then the access completes
	assign idx             = avs_address[trcc_pkg::ADDR_W-1:2];
	assign wbyte           = avs_writedata[7:0];
	assign req             = avs_read | avs_write;
	assign avs_waitrequest = ~ack_q;
	assign avs_readdata    = rdata_q;
	assign wr_acc          = avs_write & ack_q & avs_byteenable[0];

	// ack pulses for one cycle per request so back-to-back accesses stay apart
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	// read data captured in the wait cycle and held while waitrequest is low
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= 32'h0000_0000;
		end else if (avs_read && !ack_q) begin
			rdata_q <= {24'h00_0000, rd_byte};
		end
	end

	// read mux; unmapped indices read as zero
	always_comb begin
		unique case (idx)
			trcc_pkg::IDX_CAP_EN_FLAGS: rd_byte = cap_ctl_q;
			trcc_pkg::IDX_CAP_EDGE:     rd_byte = edge_q;
			trcc_pkg::IDX_CAP_FILT:     rd_byte = filt_q;
			trcc_pkg::IDX_IRQ_EN:       rd_byte = {6'h00, irq_en_q};
			trcc_pkg::IDX_TMR_CTRL:     rd_byte = ctrl_q;
			trcc_pkg::IDX_TMR_MODE:     rd_byte = mode_q;
			trcc_pkg::IDX_RLD_LO:       rd_byte = rld_q[7:0];
			trcc_pkg::IDX_RLD_HI:       rd_byte = rld_q[15:8];
			trcc_pkg::IDX_CNT_LO:       rd_byte = cnt_q[7:0];
			trcc_pkg::IDX_CNT_HI:       rd_byte = cnt_q[15:8];
			trcc_pkg::IDX_CAP0_LO:      rd_byte = cap_val[0][7:0];
			trcc_pkg::IDX_CAP0_HI:      rd_byte = cap_val[0][15:8];
			trcc_pkg::IDX_CAP1_LO:      rd_byte = cap_val[1][7:0];
			trcc_pkg::IDX_CAP1_HI:      rd_byte = cap_val[1][15:8];
			trcc_pkg::IDX_CAP2_LO:      rd_byte = cap_val[2][7:0];
			trcc_pkg::IDX_CAP2_HI:      rd_byte = cap_val[2][15:8];
			default:                    rd_byte = 8'h00;
		endcase
	end

	// write strobes
	assign wr_cnt_lo = wr_acc && idx == trcc_pkg::IDX_CNT_LO;
	assign wr_cnt_hi = wr_acc && idx == trcc_pkg::IDX_CNT_HI;
	assign wr_ctrl   = wr_acc && idx == trcc_pkg::IDX_TMR_CTRL;
	assign wr_cap_lo = {wr_acc && idx == trcc_pkg::IDX_CAP2_LO,
		wr_acc && idx == trcc_pkg::IDX_CAP1_LO, wr_acc && idx == trcc_pkg::IDX_CAP0_LO};
	assign wr_cap_hi = {wr_acc && idx == trcc_pkg::IDX_CAP2_HI,
		wr_acc && idx == trcc_pkg::IDX_CAP1_HI, wr_acc && idx == trcc_pkg::IDX_CAP0_HI};

	////////////////////////////////////////////////////////////////////////////
	// capture control registers
	// all three reset to zero
	// hardware sets flags; a set in the clear cycle wins
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cap_ctl_q <= trcc_pkg::REG_RST;
		end else begin
			cap_ctl_q <= ((wr_acc && idx == trcc_pkg::IDX_CAP_EN_FLAGS)
				? (wbyte & trcc_pkg::CAP_EN_FLAGS_MASK) : cap_ctl_q)
				| {5'h00, cap_evt};
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			edge_q <= trcc_pkg::REG_RST;
		end else if (wr_acc && idx == trcc_pkg::IDX_CAP_EDGE) begin
			edge_q <= wbyte & trcc_pkg::CAP_EDGE_MASK;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			filt_q <= trcc_pkg::REG_RST;
		end else if (wr_acc && idx == trcc_pkg::IDX_CAP_FILT) begin
			filt_q <= wbyte & trcc_pkg::CAP_FILT_MASK;
		end
	end

	// interrupt enables
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			irq_en_q <= 2'h0;
		end else if (wr_acc && idx == trcc_pkg::IDX_IRQ_EN) begin
			irq_en_q <= wbyte[1:0] & trcc_pkg::IRQ_EN_MASK[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// timer control, mode and reload/compare pair
	// flag set by overflow or match, cleared only by a write
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= trcc_pkg::REG_RST;
		end else begin
			ctrl_q <= (wr_ctrl ? (wbyte & trcc_pkg::TMR_CTRL_MASK) : ctrl_q)
				| {ovf | match, 7'h00};
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			mode_q <= trcc_pkg::REG_RST;
		end else if (wr_acc && idx == trcc_pkg::IDX_TMR_MODE) begin
			mode_q <= wbyte & trcc_pkg::TMR_MODE_MASK;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rld_q <= trcc_pkg::CNT_RST;
		end else if (wr_acc && idx == trcc_pkg::IDX_RLD_LO) begin
			rld_q <= {rld_q[15:8], wbyte};
		end else if (wr_acc && idx == trcc_pkg::IDX_RLD_HI) begin
			rld_q <= {wbyte, rld_q[7:0]};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// counter events
	assign run      = ctrl_q[trcc_pkg::CTRL_RUN_BIT];
	assign cmp_mode = ctrl_q[trcc_pkg::CTRL_MODE_BIT];
	assign any_cap  = |cap_evt;
	assign ovf      = run && cnt_q == trcc_pkg::CNT_MAX;
	// match while counting up in compare mode
	assign match    = cmp_mode && run && cnt_q == rld_q;

	always_comb begin
		unique case (mode_q[1:0])
			trcc_pkg::TRIG_OVF:  reload_evt = ovf;
			trcc_pkg::TRIG_CAP0: reload_evt = cap_evt[0];
			trcc_pkg::TRIG_CAP1: reload_evt = cap_evt[1];
			trcc_pkg::TRIG_CAP2: reload_evt = cap_evt[2];
		endcase
	end

	// capture clear beats reload in auto-reload mode
	assign cap_clr = !cmp_mode && mode_q[trcc_pkg::MODE_CAP_CLR_BIT] && any_cap;
	assign reload  = !cmp_mode && mode_q[trcc_pkg::MODE_RLD_EN_BIT] && reload_evt && !cap_clr;
	assign cmp_clr = mode_q[trcc_pkg::MODE_CMP_CLR_BIT] && match;

	// software byte writes take priority over every hardware update
	always_comb begin
		if (wr_cnt_lo) begin
			cnt_d = {cnt_q[15:8], wbyte};
		end else if (wr_cnt_hi) begin
			cnt_d = {wbyte, cnt_q[7:0]};
		// clear on the same edge that stores the value
		end else if (cap_clr) begin
			cnt_d = trcc_pkg::CNT_CLEAR;
		end else if (reload) begin
			cnt_d = rld_q;
		end else if (cmp_clr) begin
			cnt_d = trcc_pkg::CNT_CLEAR;
		end else if (run) begin
			cnt_d = cnt_q + 16'h0001;
		end else begin
			cnt_d = cnt_q;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= trcc_pkg::CNT_RST;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// capture channels
	assign pins = {capture_in_2, capture_in_1, capture_in_0};

	for (genvar ch = 0; ch < trcc_pkg::NUM_CH; ch++) begin : g_ch
		trcc_chan u_chan (
			.core_clk (core_clk),
			.rstn     (rstn),
			.pin_in   (pins[ch]),
			.chan_en  (cap_ctl_q[trcc_pkg::CAP_EN_LSB + ch]),
			.filt_en  (filt_q[trcc_pkg::FILT_EN_LSB + ch]),
			.edge_sel (edge_q[2*ch +: 2]),
			.cap_evt  (cap_evt[ch])
		);
		trcc_cap u_cap (
			.core_clk (core_clk),
			.rstn     (rstn),
			.load     (cap_evt[ch]),
			.cnt_val  (cnt_q),
			.wr_lo    (wr_cap_lo[ch]),
			.wr_hi    (wr_cap_hi[ch]),
			.wdata    (wbyte),
			.cap_q    (cap_val[ch])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// shared capture interrupt, registered
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= (|cap_ctl_q[2:0]) && irq_en_q[trcc_pkg::IRQ_CAP_EN_BIT]
				&& irq_en_q[trcc_pkg::IRQ_GLB_EN_BIT];
		end
	end
	assign capture_irq = irq_q;

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);

	reload_load_a: assert property (reload && !wr_cnt_lo && !wr_cnt_hi
		|=> cnt_q == $past(rld_q))
		else $error("reload event did not load the reload pair");
	trig_sel_a: assert property (!cmp_mode && mode_q[1:0] != 2'h0 && ovf && !any_cap
		&& !wr_cnt_lo && !wr_cnt_hi |=> cnt_q == 16'h0000)
		else $error("overflow reloaded while a capture trigger was selected");
	cap_clear_a: assert property (cap_clr && !wr_cnt_lo && !wr_cnt_hi
		|=> cnt_q == 16'h0000 ##1 !$stable(cnt_q) || !run || cnt_q == 16'h0000)
		else $error("capture auto-clear did not zero the counter");
	cmp_flag_a: assert property (cmp_mode && run && cnt_q == rld_q
		|=> ctrl_q[trcc_pkg::CTRL_FLAG_BIT])
		else $error("compare match did not set the flag");
	cmp_clear_a: assert property (cmp_clr && !any_cap && !wr_cnt_lo && !wr_cnt_hi
		|=> cnt_q == 16'h0000)
		else $error("compare auto-clear did not zero the counter");
	flag_hold_a: assert property (ctrl_q[7] && !wr_ctrl |=> ctrl_q[7])
		else $error("overflow/match flag cleared without a write");
	run_hold_a: assert property (!run && !wr_cnt_lo && !wr_cnt_hi && !any_cap
		|=> $stable(cnt_q))
		else $error("counter moved while stopped");
	cap_flag_a: assert property (any_cap |=> (cap_ctl_q[2:0] & $past(cap_evt))
		== $past(cap_evt))
		else $error("capture event did not set its flag");
	irq_out_a: assert property ((|cap_ctl_q[2:0]) && irq_en_q == 2'h3 ##1 irq_en_q == 2'h3
		|-> capture_irq)
		else $error("capture interrupt missing");
	bus_answer_a: assert property (req && !ack_q |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not one cycle after the request");

	reload_seen_c: cover property (reload);
	cap_clear_c:   cover property (cap_clr);
	cmp_match_c:   cover property (match ##1 ctrl_q[7]);
	irq_seen_c:    cover property ($rose(capture_irq));

endmodule : trcc_top

// File: trcc_src.sv
// trcc_src: stand-in for the external signal sources on the three capture pins
module trcc_src (
	// clock
	input  wire logic       core_clk,
	// capture pins
	output logic      [2:0] pin
);
	timeunit 1ns;
	timeprecision 1ns;

	////////////////////////////////////////////////////////////////////////////
	// pins idle low; every change lands just after a rising edge to avoid races
	initial pin = 3'h0;

	task automatic set(input int ch, input logic v);
		@(posedge core_clk);
		pin[ch] <= v;
	endtask : set

	// high pulse of n cycles, then a quiet gap so filter and flags settle
	task automatic pulse(input int ch, input int n);
		set(ch, 1'b1);
		repeat (n - 1) @(posedge core_clk);
		set(ch, 1'b0);
		repeat (8) @(posedge core_clk);
	endtask : pulse
endmodule : trcc_src

// File: test_trcc_top.sv
// test_trcc_top: self-checking bench for the reload/compare timer with capture
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
	$display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module test_trcc_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk, rstn, avs_read, avs_write, avs_waitrequest, capture_irq;
	logic [9:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0]  avs_byteenable;
	logic [2:0]  pin;
	logic [7:0]  rv;
	int          err_total, samples_checked, cyc;

	trcc_top trcc_top_i (.core_clk(core_clk), .rstn(rstn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .capture_in_0(pin[0]), .capture_in_1(pin[1]),
		.capture_in_2(pin[2]), .capture_irq(capture_irq));
	trcc_src trcc_src_i (.core_clk(core_clk), .pin(pin));

	////////////////////////////////////////////////////////////////////////////
	// clock, and a cycle ceiling so a stuck handshake cannot hang the run
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			summarize();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// one bus access; request held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		@(posedge core_clk);
		avs_address <= {idx, 2'h0};
		avs_read <= ~w;
		avs_write <= w;
		avs_writedata <= {24'h000000, wd};
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		rv = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d);
	endtask : wr
	task automatic rdc(input logic [7:0] idx, input logic [7:0] e, input string nm);
		bus(1'b0, idx, 8'h00);
		`CHK(nm, e, rv)
	endtask : rdc

	////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset();
		rdc(trcc_pkg::IDX_CAP_EN_FLAGS, 8'h00, "enflags");
		rdc(trcc_pkg::IDX_CAP_EDGE, 8'h00, "edge");
		rdc(trcc_pkg::IDX_CAP_FILT, 8'h00, "filt");
		wr(8'h00, 8'hFF);
		rdc(8'h00, 8'h00, "unmapped");
		$display("reset done");
	endtask : t_reset

	// timer stopped so the captured value is known exactly; an armed reload must lose
	task automatic t_capture();
		wr(trcc_pkg::IDX_CNT_LO, 8'h3C);
		wr(trcc_pkg::IDX_CNT_HI, 8'h5A);
		wr(trcc_pkg::IDX_RLD_HI, 8'h77);
		wr(trcc_pkg::IDX_TMR_MODE, 8'h89);
		wr(trcc_pkg::IDX_CAP_EDGE, 8'h01);
		wr(trcc_pkg::IDX_CAP_EN_FLAGS, 8'h10);
		wr(trcc_pkg::IDX_IRQ_EN, 8'h03);
		trcc_src_i.pulse(0, 6);
		@(posedge core_clk);
		`CHK("irq", 1'b1, capture_irq)
		rdc(trcc_pkg::IDX_CAP_EN_FLAGS, 8'h11, "flag0");
		rdc(trcc_pkg::IDX_CAP0_LO, 8'h3C, "cap0lo");
		rdc(trcc_pkg::IDX_CAP0_HI, 8'h5A, "cap0hi");
		rdc(trcc_pkg::IDX_CNT_LO, 8'h00, "cntlo");
		rdc(trcc_pkg::IDX_CNT_HI, 8'h00, "cnthi");
		wr(trcc_pkg::IDX_CAP_EN_FLAGS, 8'h10);
		repeat (3) @(posedge core_clk);
		`CHK("irqoff", 1'b0, capture_irq)
		$display("capture done");
	endtask : t_capture

	task automatic t_refuse();
		wr(trcc_pkg::IDX_CAP_EDGE, 8'h03);
		trcc_src_i.pulse(0, 6);
		rdc(trcc_pkg::IDX_CAP_EN_FLAGS, 8'h10, "reserved");
		wr(trcc_pkg::IDX_CAP_EN_FLAGS, 8'h00);
		wr(trcc_pkg::IDX_CAP_EDGE, 8'h02);
		trcc_src_i.pulse(0, 6);
		rdc(trcc_pkg::IDX_CAP_EN_FLAGS, 8'h00, "disabled");
		$display("refuse done");
	endtask : t_refuse

	// filter on channel 1, then the either-edge code with filter off
	task automatic t_filter();
		wr(trcc_pkg::IDX_CAP_FILT, 8'h20);
		wr(trcc_pkg::IDX_CAP_EDGE, 8'h04);
		wr(trcc_pkg::IDX_CAP_EN_FLAGS, 8'h20);
		trcc_src_i.pulse(1, 3);
		rdc(trcc_pkg::IDX_CAP_EN_FLAGS, 8'h20, "short");
		trcc_src_i.pulse(1, 4);
		rdc(trcc_pkg::IDX_CAP_EN_FLAGS, 8'h22, "four");
		wr(trcc_pkg::IDX_CAP_FILT, 8'h00);
		wr(trcc_pkg::IDX_CAP_EDGE, 8'h08);
		wr(trcc_pkg::IDX_CAP_EN_FLAGS, 8'h20);
		trcc_src_i.set(1, 1'b1);
		repeat (6) @(posedge core_clk);
		rdc(trcc_pkg::IDX_CAP_EN_FLAGS, 8'h22, "anyrise");
		wr(trcc_pkg::IDX_CAP_EN_FLAGS, 8'h20);
		trcc_src_i.set(1, 1'b0);
		repeat (6) @(posedge core_clk);
		rdc(trcc_pkg::IDX_CAP_EN_FLAGS, 8'h22, "anyfall");
		$display("filter done");
	endtask : t_filter

	// falling edge on channel 2 triggers the reload
	task automatic t_reload();
		wr(trcc_pkg::IDX_TMR_MODE, 8'h83);
		wr(trcc_pkg::IDX_RLD_LO, 8'h34);
		wr(trcc_pkg::IDX_RLD_HI, 8'h12);
		wr(trcc_pkg::IDX_CAP_EDGE, 8'h00);
		wr(trcc_pkg::IDX_CAP_EN_FLAGS, 8'h40);
		trcc_src_i.pulse(2, 6);
		rdc(trcc_pkg::IDX_CNT_LO, 8'h34, "rldlo");
		rdc(trcc_pkg::IDX_CNT_HI, 8'h12, "rldhi");
		rdc(trcc_pkg::IDX_CAP_EN_FLAGS, 8'h44, "flag2");
		$display("reload done");
	endtask : t_reload

	task automatic t_compare();
		wr(trcc_pkg::IDX_TMR_MODE, 8'h00);
		wr(trcc_pkg::IDX_RLD_LO, 8'h10);
		wr(trcc_pkg::IDX_RLD_HI, 8'h00);
		wr(trcc_pkg::IDX_CNT_LO, 8'h00);
		wr(trcc_pkg::IDX_CNT_HI, 8'h00);
		wr(trcc_pkg::IDX_TMR_CTRL, 8'h05);
		repeat (30) @(posedge core_clk);
		rdc(trcc_pkg::IDX_TMR_CTRL, 8'h85, "match");
		wr(trcc_pkg::IDX_TMR_CTRL, 8'h01);
		rdc(trcc_pkg::IDX_TMR_CTRL, 8'h01, "flagclr");
		// with auto-clear the count never leaves the low byte
		wr(trcc_pkg::IDX_TMR_MODE, 8'h04);
		wr(trcc_pkg::IDX_CNT_LO, 8'h00);
		wr(trcc_pkg::IDX_TMR_CTRL, 8'h05);
		repeat (300) @(posedge core_clk);
		wr(trcc_pkg::IDX_TMR_CTRL, 8'h01);
		rdc(trcc_pkg::IDX_CNT_HI, 8'h00, "cmpclr");
		$display("compare done");
	endtask : t_compare

	// overflow reloads a high pair, so the high byte never wraps to zero
	task automatic t_overflow();
		wr(trcc_pkg::IDX_TMR_MODE, 8'h80);
		wr(trcc_pkg::IDX_RLD_LO, 8'h00);
		wr(trcc_pkg::IDX_RLD_HI, 8'hFF);
		wr(trcc_pkg::IDX_CNT_LO, 8'h00);
		wr(trcc_pkg::IDX_CNT_HI, 8'hFF);
		wr(trcc_pkg::IDX_TMR_CTRL, 8'h04);
		repeat (300) @(posedge core_clk);
		rdc(trcc_pkg::IDX_TMR_CTRL, 8'h84, "ovfflag");
		wr(trcc_pkg::IDX_TMR_CTRL, 8'h00);
		rdc(trcc_pkg::IDX_CNT_HI, 8'hFF, "ovfrld");
		wr(trcc_pkg::IDX_CNT_LO, 8'h5A);
		repeat (20) @(posedge core_clk);
		rdc(trcc_pkg::IDX_CNT_LO, 8'h5A, "stopped");
		$display("overflow done");
	endtask : t_overflow

	task automatic summarize();
		$display("checked %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize

	////////////////////////////////////////////////////////////////////////////
	// reset held for 16 cycles, then the scenarios in turn
	initial begin
		{rstn, avs_read, avs_write, avs_address, avs_writedata} = '0;
		avs_byteenable = 4'hF;
		repeat (16) @(posedge core_clk);
		rstn <= 1'b1;
		t_reset();
		t_capture();
		t_refuse();
		t_filter();
		t_reload();
		t_compare();
		t_overflow();
		summarize();
	end
endmodule : test_trcc_top
